// [scfp_port.sv]
// serial slave port: configuration registers, strobes, status reads and transmit fifo
// Overview of operation
// - all bytes shifted most significant bit first
// - header is rw flag, burst flag, address
// - chip select rise abandons the access
// - output low once supply and oscillator ready
// - status top bit is not-ready flag
// - status bits 6:4 give main state
// - status bits 3:0 give saturated free count
// - configuration registers readable and writable
// - status byte returned during each write byte
// - burst address counter steps every byte of a configuration register burst; held at the fifo address
// - rw flag picks status read or strobe
// - strobe is a header alone
// - power down and osc off wait chip select
// - fifo at 0x3f, write only
// - 0x3f single byte, 0x7f burst bytes
// - free count taken before byte in progress
// - fifo emptied on flush and sleep
// - idle 000, underflow 111 until flush
`timescale 1ns/1ps
module scfp_port (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_sclk,
   input wire logic i_chip_select_n,
   input wire logic i_si,
   input wire logic i_supply_osc_not_ready,
   input wire logic [2:0] i_main_state,
   input wire logic i_sleep,
   input wire logic i_fifo_pop,
   input wire logic [7:0] i_status_reg_data,
   output logic o_so,
   output logic o_so_oe,
   output logic o_cfg_we,
   output logic [5:0] o_cfg_addr,
   output logic [7:0] o_cfg_wdata,
   output logic o_strobe,
   output logic [5:0] o_strobe_addr,
   output logic o_fifo_empty,
   output logic [7:0] o_fifo_rdata,
   output logic [6:0] o_fifo_count
);
   logic [2:0] sclk_sync;
   logic [1:0] csn_sync;
   logic [1:0] si_sync;
   logic csn_q;
   logic rise;
   logic fall;
   logic csn_rise;
   scfp_pkg::scfp_phase_e phase;
   logic [2:0] bit_cnt;
   logic [7:0] shift_in;
   logic [7:0] shift_out;
   logic [7:0] next_byte;
   logic byte_done;
   logic rw;
   logic burst;
   logic [5:0] addr;
   logic [7:0] cfg_mem [0:47];
   logic [7:0] fifo_mem [0:63];
   logic [5:0] wr_ptr;
   logic [5:0] rd_ptr;
   logic [6:0] count;
   logic fifo_push;
   logic flush;
   logic pend_pd;
   logic pend_off;
   logic [7:0] status_byte;
   logic [3:0] free_field;
   logic [6:0] free_cnt;
   logic [5:0] hdr_addr;
   logic is_strobe_hdr;

   // pin inputs pass two flops, sclk three; edges use the second and third stage only
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         sclk_sync <= 3'h0;
         csn_sync <= 2'h3;
         si_sync <= 2'h0;
         csn_q <= 1'b1;
      end
      else
      begin
         sclk_sync <= {sclk_sync[1:0], i_sclk};
         csn_sync <= {csn_sync[0], i_chip_select_n};
         si_sync <= {si_sync[0], i_si};
         csn_q <= csn_sync[1];
      end
   end

   assign rise = sclk_sync[1] & ~sclk_sync[2] & ~csn_sync[1];
   assign fall = ~sclk_sync[1] & sclk_sync[2] & ~csn_sync[1];
   assign csn_rise = csn_sync[1] & ~csn_q;
   assign next_byte = {shift_in[6:0], si_sync[1]};
   assign byte_done = rise && (bit_cnt == 3'h7);
   assign hdr_addr = next_byte[5:0];
   assign is_strobe_hdr = (hdr_addr >= scfp_pkg::strobe_first_addr) && (hdr_addr <= scfp_pkg::strobe_last_addr);

   // saturate free count; count sampled before the byte lands
   assign free_cnt = 7'(scfp_pkg::fifo_depth) - count;
   assign free_field = (free_cnt >= 7'(scfp_pkg::free_sat)) ? scfp_pkg::free_sat : free_cnt[3:0];
   // not-ready flag on top; state field passes the main state
   // main state codes pass unchanged, idle 000 and underflow 111
   assign status_byte = {i_supply_osc_not_ready, i_main_state, free_field};

   // burst counter; chip select rise resets framing
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n || csn_sync[1])
      begin
         phase <= scfp_pkg::scfp_header;
         bit_cnt <= 3'h0;
         shift_in <= 8'h00;
         rw <= 1'b0;
         burst <= 1'b0;
         addr <= 6'h00;
      end
      else if (rise)
      begin
         bit_cnt <= bit_cnt + 3'h1;
         shift_in <= next_byte;
         if (byte_done)
         begin
            case (phase)
               scfp_pkg::scfp_header:
               begin
                  rw <= next_byte[scfp_pkg::hdr_rw_bit];
                  burst <= next_byte[scfp_pkg::hdr_burst_bit];
                  addr <= hdr_addr;
                  // strobe header needs no data; fifo reads are ignored
                  if (!next_byte[7] && !next_byte[6] && is_strobe_hdr)
                     phase <= scfp_pkg::scfp_header;
                  else if (next_byte[7] && hdr_addr == scfp_pkg::fifo_addr)
                     phase <= scfp_pkg::scfp_skip;
                  else
                     phase <= scfp_pkg::scfp_data;
               end
               scfp_pkg::scfp_data:
               begin
                  // single access returns to header; status reads single only
                  if (!burst || (addr >= scfp_pkg::strobe_first_addr && addr != scfp_pkg::fifo_addr))
                     phase <= burst ? scfp_pkg::scfp_skip : scfp_pkg::scfp_header;
                  else if (addr != scfp_pkg::fifo_addr)
                     addr <= addr + 6'h1;
               end
               default:
                  phase <= scfp_pkg::scfp_skip;
            endcase
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         o_cfg_we <= 1'b0;
         o_cfg_addr <= 6'h00;
         o_cfg_wdata <= 8'h00;
      end
      else
      begin
         o_cfg_we <= byte_done && phase == scfp_pkg::scfp_data && !rw && addr <= scfp_pkg::cfg_last_addr;
         if (byte_done && phase == scfp_pkg::scfp_data)
         begin
            o_cfg_addr <= addr;
            o_cfg_wdata <= next_byte;
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (byte_done && phase == scfp_pkg::scfp_data && !rw && addr <= scfp_pkg::cfg_last_addr)
         cfg_mem[addr] <= next_byte;
   end

   // immediate strobes now, one deferred strobe at chip select rise: power down if pending, else osc off
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         o_strobe <= 1'b0;
         o_strobe_addr <= 6'h00;
         pend_pd <= 1'b0;
         pend_off <= 1'b0;
      end
      else
      begin
         o_strobe <= 1'b0;
         if (byte_done && phase == scfp_pkg::scfp_header && next_byte[7:6] == 2'b00 && is_strobe_hdr)
         begin
            if (hdr_addr == scfp_pkg::strobe_power_down)
               pend_pd <= 1'b1;
            else if (hdr_addr == scfp_pkg::strobe_osc_off)
               pend_off <= 1'b1;
            else
            begin
               o_strobe <= 1'b1;
               o_strobe_addr <= hdr_addr;
            end
         end
         else if (csn_rise && (pend_pd || pend_off))
         begin
            o_strobe <= 1'b1;
            o_strobe_addr <= pend_pd ? scfp_pkg::strobe_power_down : scfp_pkg::strobe_osc_off;
            pend_pd <= 1'b0;
            pend_off <= 1'b0;
         end
      end
   end

   assign flush = i_sleep || (byte_done && phase == scfp_pkg::scfp_header && next_byte[7:6] == 2'b00
                  && hdr_addr == scfp_pkg::strobe_tx_flush);
   // write only fifo, full drops the byte
   assign fifo_push = byte_done && phase == scfp_pkg::scfp_data && !rw && addr == scfp_pkg::fifo_addr
                      && count != 7'(scfp_pkg::fifo_depth);

   always_ff @(posedge i_clk)
   begin
      if (fifo_push)
         fifo_mem[wr_ptr] <= next_byte;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n || flush)
      begin
         wr_ptr <= 6'h00;
         rd_ptr <= 6'h00;
         count <= 7'h00;
      end
      else
      begin
         if (fifo_push)
            wr_ptr <= wr_ptr + 6'h1;
         if (i_fifo_pop && count != 7'h00)
            rd_ptr <= rd_ptr + 6'h1;
         count <= count + 7'(fifo_push) - 7'(i_fifo_pop && count != 7'h00);
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         o_fifo_empty <= 1'b1;
         o_fifo_rdata <= 8'h00;
         o_fifo_count <= 7'h00;
      end
      else
      begin
         o_fifo_empty <= (count == 7'h00);
         o_fifo_rdata <= fifo_mem[rd_ptr];
         o_fifo_count <= count;
      end
   end

   // output shifts on falling edges; status during every write byte
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n || csn_sync[1])
         shift_out <= 8'h00;
      else if (csn_q && !csn_sync[1])
         shift_out <= status_byte;
      else if (fall && bit_cnt == 3'h0)
      begin
         if (phase == scfp_pkg::scfp_data && rw)
            shift_out <= {(addr <= scfp_pkg::cfg_last_addr) ? cfg_mem[addr] : i_status_reg_data};
         else
            shift_out <= status_byte;
      end
      else if (fall)
         shift_out <= {shift_out[6:0], 1'b0};
   end

   // hold output high until ready, then present status msb
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         o_so <= 1'b1;
         o_so_oe <= 1'b0;
      end
      else
      begin
         o_so_oe <= ~csn_sync[1];
         o_so <= (bit_cnt == 3'h0 && phase == scfp_pkg::scfp_header) ?
                 i_supply_osc_not_ready : shift_out[7];
      end
   end

   // a select rise must clear the framing
   a_cancel_on_csn: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      csn_rise |=> bit_cnt == 3'h0 && phase == scfp_pkg::scfp_header)
      else $error("framing not cleared on select rise");
   a_so_idle_high: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      csn_sync[1] |=> !o_so_oe)
      else $error("output driven while deselected");
   // below fifteen free bytes the field is exact, otherwise it saturates
   a_status_field: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (count > 7'h31 && status_byte[3:0] == 4'(7'(scfp_pkg::fifo_depth) - count))
      || (count <= 7'h31 && status_byte[3:0] == scfp_pkg::free_sat))
      else $error("free count field wrong");
   // the state code must reach the shifter loaded at select fall
   a_state_field: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      csn_q && !csn_sync[1] |=> shift_out[6:4] == $past(i_main_state))
      else $error("state field mismatch");
   a_fifo_push_cnt: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      fifo_push && !flush && !i_fifo_pop |=> count == $past(count) + 7'h1)
      else $error("fifo count did not step");
   a_fifo_full_drop: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      count == 7'(scfp_pkg::fifo_depth) && !flush && !i_fifo_pop |=> count == $past(count))
      else $error("full fifo took a byte");
   a_flush_empties: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      flush |=> count == 7'h00 ##1 o_fifo_empty)
      else $error("flush left data");
   a_deferred_strobe: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_strobe && (o_strobe_addr == scfp_pkg::strobe_power_down || o_strobe_addr == scfp_pkg::strobe_osc_off)
      |-> $past(csn_rise))
      else $error("power down strobe not deferred");
   a_strobe_now: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      byte_done && phase == scfp_pkg::scfp_header && next_byte[7:6] == 2'b00 && is_strobe_hdr
      && hdr_addr != scfp_pkg::strobe_power_down && hdr_addr != scfp_pkg::strobe_osc_off
      |=> o_strobe && o_strobe_addr == $past(hdr_addr))
      else $error("immediate strobe not issued");
   a_burst_addr_step: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      byte_done && phase == scfp_pkg::scfp_data && burst && addr <= scfp_pkg::cfg_last_addr
      |=> addr == $past(addr) + 6'h1)
      else $error("burst address did not step");
   a_cfg_write_dir: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_cfg_we |-> !rw && o_cfg_addr <= scfp_pkg::cfg_last_addr)
      else $error("config write on read access");
   c_burst_fifo: cover property (@(posedge i_clk) disable iff (!i_rst_n) fifo_push ##[1:200] fifo_push);
   c_strobe: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_strobe);
   c_cfg_write: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_cfg_we);
   // flush issued while the main machine reports underflow
   c_underflow_flush: cover property (@(posedge i_clk) disable iff (!i_rst_n)
      i_main_state == scfp_pkg::state_tx_underflow && flush);
   c_status_read: cover property (@(posedge i_clk) disable iff (!i_rst_n)
      byte_done && phase == scfp_pkg::scfp_data && rw && addr >= scfp_pkg::strobe_first_addr);
endmodule

// [scfp_pkg.sv]
// constants for the serial configuration and fifo port
package scfp_pkg;
   localparam int unsigned addr_w = 6;
   localparam int unsigned fifo_depth = 64;
   localparam int unsigned cnt_w = 7;
   localparam logic [5:0] cfg_last_addr = 6'h2f;
   localparam logic [5:0] strobe_first_addr = 6'h30;
   localparam logic [5:0] strobe_last_addr = 6'h3d;
   localparam logic [5:0] fifo_addr = 6'h3f;
   localparam int unsigned hdr_rw_bit = 7;
   localparam int unsigned hdr_burst_bit = 6;
   localparam int unsigned stat_rdy_bit = 7;
   localparam logic [3:0] free_sat = 4'hf;
   localparam logic [2:0] state_idle = 3'h0;
   localparam logic [2:0] state_tx_underflow = 3'h7;
   localparam logic [7:0] cfg_reset_value = 8'h00;
   // strobe addresses inside 0x30..0x3d; exact values chosen for this block
   localparam logic [5:0] strobe_osc_off = 6'h32;
   localparam logic [5:0] strobe_power_down = 6'h39;
   localparam logic [5:0] strobe_tx_flush = 6'h3b;
   typedef enum logic [1:0] {scfp_header, scfp_data, scfp_skip} scfp_phase_e;
endpackage

// [scfp_host.sv]
// serial bus master model standing on the host side of the port
`timescale 1ns/1ps
module scfp_host (
   input wire logic i_clk,
   input wire logic i_so,
   output logic o_sclk,
   output logic o_csn,
   output logic o_si
);
   initial
   begin
      o_sclk = 1'b0;
      o_csn = 1'b1;
      o_si = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic open_frame(output logic ok);
      o_csn <= 1'b0;
      ok = 1'b0;
      // the released pin may read low by chance, so trust it only once the slave can have taken the select
      wait_clk(4);
      for (int i = 0; i < 400 && !ok; i++)
      begin
         @(posedge i_clk);
         ok = (i_so === 1'b0);
      end
   endtask
   // msb first, sampled just before the fall so output has settled
   task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
      for (int b = 7; b > 7 - nbits; b--)
      begin
         o_si <= tx[b];
         wait_clk(4);
         o_sclk <= 1'b1;
         wait_clk(4);
         rx[b] = i_so;
         o_sclk <= 1'b0;
      end
   endtask
   // released data line shows the inverse of its last bit
   task automatic close_frame;
      o_csn <= 1'b1;
      o_si <= ~o_si;
      wait_clk(8);
   endtask
endmodule

// [tb_spi_config_fifo_port.sv]
// self-checking bench for the serial configuration and fifo port
`timescale 1ns/1ps
module tb_spi_config_fifo_port;
   logic i_clk, i_rst_n, sclk, chip_select_n, si, nrdy, sleep, pop, ok;
   logic so, so_oe, cfg_we, strobe, empty;
   logic [2:0] mstate;
   logic [5:0] cfg_addr, strobe_addr, we_addr, stb_addr;
   logic [7:0] sreg, rx, cfg_wdata, fifo_rdata, we_data;
   logic [6:0] fifo_count;
   int n_errors = 0, comparisons = 0, n_we = 0, n_stb = 0, s0;
   initial
   begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   always @(posedge i_clk)
   begin
      if (cfg_we === 1'b1)
      begin
         n_we <= n_we + 1;
         we_addr <= cfg_addr;
         we_data <= cfg_wdata;
      end
      if (strobe === 1'b1)
      begin
         n_stb <= n_stb + 1;
         stb_addr <= strobe_addr;
      end
   end
   scfp_port dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sclk(sclk), .i_chip_select_n(chip_select_n), .i_si(si),
      .i_supply_osc_not_ready(nrdy), .i_main_state(mstate), .i_sleep(sleep), .i_fifo_pop(pop),
      .i_status_reg_data(sreg), .o_so(so), .o_so_oe(so_oe), .o_cfg_we(cfg_we), .o_cfg_addr(cfg_addr),
      .o_cfg_wdata(cfg_wdata), .o_strobe(strobe), .o_strobe_addr(strobe_addr), .o_fifo_empty(empty),
      .o_fifo_rdata(fifo_rdata), .o_fifo_count(fifo_count));
   scfp_host host (.i_clk(i_clk), .i_so(so_oe ? so : ~so), .o_sclk(sclk), .o_csn(chip_select_n), .o_si(si));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   function automatic logic [7:0] stat(input int free);
      return {1'b0, mstate, (free > 15) ? 4'hf : 4'(free)};
   endfunction
   task automatic put(input logic [7:0] tx, input logic [7:0] exp);
      host.xfer(tx, 8, rx);
      check(rx, exp);
      host.wait_clk(8);
   endtask
   task automatic t_ready;
      nrdy <= 1'b1;
      host.open_frame(ok);
      check({ok, so, so_oe}, 3'h3);
      nrdy <= 1'b0;
      host.open_frame(ok);
      check(ok, 1'b1);
      host.close_frame();
      check(so_oe, 1'b0);
      $display("test ready done");
   endtask
   task automatic t_cfg;
      mstate <= 3'h0;
      sreg <= 8'h5c;
      host.open_frame(ok);
      put(8'h05, stat(64));
      put(8'ha5, stat(64));
      check({we_addr, we_data}, {6'h05, 8'ha5});
      put(8'h50, stat(64));
      put(8'h11, stat(64));
      put(8'h22, stat(64));
      check({we_addr, we_data, 8'(n_we)}, {6'h11, 8'h22, 8'h03});
      host.close_frame();
      host.open_frame(ok);
      put(8'h85, stat(64));
      put(8'h00, 8'ha5);
      put(8'hd0, stat(64));
      put(8'h00, 8'h11);
      put(8'h00, 8'h22);
      host.close_frame();
      host.open_frame(ok);
      put(8'hf5, stat(64));
      put(8'h00, 8'h5c);
      host.close_frame();
      host.open_frame(ok);
      put(8'h07, stat(64));
      host.xfer(8'h99, 4, rx);
      host.close_frame();
      check(n_we, 3);
      $display("test cfg done");
   endtask
   task automatic t_strobe;
      mstate <= 3'h7;
      s0 = n_stb;
      host.open_frame(ok);
      for (int a = 8'h30; a <= 8'h3d; a++)
         put(8'(a), stat(64));
      check({8'(n_stb - s0), stb_addr}, {8'h0c, 6'h3d});
      host.close_frame();
      check({8'(n_stb - s0), stb_addr}, {8'h0d, 6'h39});
      $display("test strobe done");
   endtask
   task automatic t_fifo;
      mstate <= 3'h1;
      host.open_frame(ok);
      put(8'h7f, stat(64));
      for (int k = 0; k < 64; k++)
         put(8'(k + 1), stat(64 - k));
      put(8'hee, stat(0));
      host.close_frame();
      check({fifo_count, fifo_rdata}, {7'h40, 8'h01});
      pop <= 1'b1;
      host.wait_clk(1);
      pop <= 1'b0;
      host.open_frame(ok);
      put(8'hbf, stat(1));
      put(8'h55, stat(1));
      host.close_frame();
      check({fifo_count, fifo_rdata}, {7'h3f, 8'h02});
      host.open_frame(ok);
      put(8'h3b, stat(1));
      check({empty, fifo_count}, {1'b1, 7'h00});
      put(8'h3f, stat(64));
      put(8'h77, stat(64));
      put(8'h3f, stat(63));
      put(8'h88, stat(63));
      host.close_frame();
      check({fifo_count, fifo_rdata}, {7'h02, 8'h77});
      sleep <= 1'b1;
      host.wait_clk(2);
      sleep <= 1'b0;
      host.wait_clk(3);
      check({empty, fifo_count}, {1'b1, 7'h00});
      $display("test fifo done");
   endtask
   initial
   begin
      i_rst_n = 1'b0;
      {nrdy, sleep, pop} = 3'h0;
      mstate = 3'h0;
      sreg = 8'h00;
      repeat (12) @(posedge i_clk);
      i_rst_n <= 1'b1;
      host.wait_clk(3);
      t_ready();
      t_cfg();
      t_strobe();
      t_fifo();
      end_of_test();
   end
   initial
   begin
      repeat (60000) @(posedge i_clk);
      n_errors++;
      end_of_test();
   end
endmodule
